// *** src/ttcrb_timer.v ***
// 16-bit timer/counter with auto-reload, capture and baud generation
// Assumes one core clock, APB master on the same clock, async pins
//
// Behaviour
// - Overflow flag sets on rollover, not baud
// - Trigger capture/reload with enable sets event flag
// - Receive baud select picks receiver overflow source
// - Transmit baud select picks transmitter overflow source
// - Trigger acts only when enabled and running
// - Counts only while run bit set
// - Source select: pin edges or core ticks
// - Capture select; ignored in baud, reload then
// - Mode decode from run, baud, capture bits
// - Auto-reload: rollover flags and reloads
// - Auto-reload: trigger edge reloads, sets flag
// - Capture mode: free-running, overflow interrupts
// - Capture mode: trigger copies count, sets flag
// - Baud: no overflow flag, trigger still flags
// - Count and reload byte pairs, read/write
`timescale 1ns/1ps
`include "ttcrb_map.vh"

module ttcrb_timer
(
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ext_count_pin,
    input wire trigger_pin,
    input wire other_timer_ovf,
    output reg rx_baud_tick,
    output reg tx_baud_tick,
    output reg baud_ovf_pulse,
    output reg irq
);

    // ****************************************
    // Mode encoding
    // ****************************************
    localparam [3:0] MODE_OFF = 4'b0001;
    localparam [3:0] MODE_RELOAD = 4'b0010;
    localparam [3:0] MODE_CAPTURE = 4'b0100;
    localparam [3:0] MODE_BAUD = 4'b1000;

    // ****************************************
    // State
    // ****************************************
    reg [7:0] ctrl_q;
    reg [15:0] rcap_q;
    reg [15:0] cnt_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_en_q;
    reg [3:0] div_q;
    reg [1:0] cnt_sync_q;
    reg [1:0] trg_sync_q;
    reg cnt_prev_q;
    reg trg_prev_q;
    reg [3:0] mode;
    reg [31:0] rd_data;
    reg rd_err;

    wire rx_sel = ctrl_q[`TTCRB_B_RXSEL];
    wire tx_sel = ctrl_q[`TTCRB_B_TXSEL];
    wire exen = ctrl_q[`TTCRB_B_EXEN];
    wire run = ctrl_q[`TTCRB_B_RUN];
    wire cnt_src = ctrl_q[`TTCRB_B_CNTSRC];
    wire cap_sel = ctrl_q[`TTCRB_B_CAPSEL];
    wire baud_on = rx_sel | tx_sel;

    // ****************************************
    // APB decode
    // ****************************************
    // One wait state: pready rises in the second access cycle
    wire acc = psel & penable & ~pready;
    wire done = psel & penable & pready;
    wire wr = done & pwrite & ~pslverr;
    wire hit_ctrl = (paddr == {2'b00, `TTCRB_IDX_CTRL, 2'b00});
    wire hit_rlo = (paddr == {2'b00, `TTCRB_IDX_RCAP_LO, 2'b00});
    wire hit_rhi = (paddr == {2'b00, `TTCRB_IDX_RCAP_HI, 2'b00});
    wire hit_clo = (paddr == {2'b00, `TTCRB_IDX_CNT_LO, 2'b00});
    wire hit_chi = (paddr == {2'b00, `TTCRB_IDX_CNT_HI, 2'b00});
    wire hit_ist = (paddr == {2'b00, `TTCRB_IDX_IRQ_STAT, 2'b00});
    wire hit_icl = (paddr == {2'b00, `TTCRB_IDX_IRQ_CLR, 2'b00});
    wire hit_ien = (paddr == {2'b00, `TTCRB_IDX_IRQ_EN, 2'b00});

    // Read mux and error decode; clear register reads as zero
    always @*
    begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        case (1'b1)
            hit_ctrl: rd_data = {24'h000000, ctrl_q};
            hit_rlo: rd_data = {24'h000000, rcap_q[7:0]};
            hit_rhi: rd_data = {24'h000000, rcap_q[15:8]};
            hit_clo: rd_data = {24'h000000, cnt_q[7:0]};
            hit_chi: rd_data = {24'h000000, cnt_q[15:8]};
            hit_ist: rd_data = {30'h0, irq_stat_q};
            hit_icl: rd_data = 32'h00000000;
            hit_ien: rd_data = {30'h0, irq_en_q};
            default: rd_err = 1'b1;
        endcase
        // Status register is read only; clear register is write only
        if (pwrite && hit_ist)
        begin
            rd_err = 1'b1;
        end
    end

    // Bus answer flops
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (acc)
        begin
            pready <= 1'b1;
            pslverr <= rd_err;
            prdata <= pwrite ? 32'h00000000 : rd_data;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    // Edge detect reads only the second stage, never the first
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_sync_q <= 2'b11;
            trg_sync_q <= 2'b11;
            cnt_prev_q <= 1'b1;
            trg_prev_q <= 1'b1;
        end
        else
        begin
            cnt_sync_q <= {cnt_sync_q[0], ext_count_pin};
            trg_sync_q <= {trg_sync_q[0], trigger_pin};
            cnt_prev_q <= cnt_sync_q[1];
            trg_prev_q <= trg_sync_q[1];
        end
    end

    wire cnt_fall = cnt_prev_q & ~cnt_sync_q[1];
    wire trg_fall = trg_prev_q & ~trg_sync_q[1];

    // ****************************************
    // Mode decode
    // ****************************************
    always @*
    begin
        if (!run)
        begin
            mode = MODE_OFF;
        end
        else if (baud_on)
        begin
            mode = MODE_BAUD;
        end
        else if (cap_sel)
        begin
            mode = MODE_CAPTURE;
        end
        else
        begin
            mode = MODE_RELOAD;
        end
    end

    // ****************************************
    // Tick generation
    // ****************************************
    // Baud mode runs the core-clock divider faster, as a classic
    // baud generator does; off mode holds the divider in reset
    wire [3:0] div_end = (mode == MODE_BAUD) ? `TTCRB_DIV_BAUD : `TTCRB_DIV_TIMER;
    wire core_tick = (div_q == div_end - 4'd1);

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= 4'd0;
        end
        else if (mode == MODE_OFF || core_tick || div_q >= div_end)
        begin
            div_q <= 4'd0;
        end
        else
        begin
            div_q <= div_q + 4'd1;
        end
    end

    // Count source: pin falling edge or core-derived tick
    wire src_tick = cnt_src ? cnt_fall : core_tick;
    wire inc = (mode != MODE_OFF) & src_tick;
    wire roll = inc & (cnt_q == 16'hffff);

    // Trigger acts only with enable set and a running timer
    wire trg_evt = trg_fall & exen & (mode != MODE_OFF);
    wire do_reload = (roll & (mode == MODE_RELOAD || mode == MODE_BAUD))
        | (trg_evt & (mode == MODE_RELOAD));
    wire do_capture = trg_evt & (mode == MODE_CAPTURE);
    wire set_ovf = roll & (mode != MODE_BAUD);
    wire set_ext = trg_evt;

    // ****************************************
    // Counter
    // ****************************************
    // Software byte writes win over counting in the same cycle
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= `TTCRB_RST_CNT;
        end
        else if (wr && hit_clo)
        begin
            cnt_q[7:0] <= pwdata[7:0];
        end
        else if (wr && hit_chi)
        begin
            cnt_q[15:8] <= pwdata[7:0];
        end
        else if (do_reload)
        begin
            cnt_q <= rcap_q;
        end
        else if (inc)
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // ****************************************
    // Reload / capture register pair
    // ****************************************
    // Capture takes precedence over a software write in one cycle
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rcap_q <= `TTCRB_RST_RCAP;
        end
        else if (do_capture)
        begin
            rcap_q <= cnt_q;
        end
        else if (wr && hit_rlo)
        begin
            rcap_q[7:0] <= pwdata[7:0];
        end
        else if (wr && hit_rhi)
        begin
            rcap_q[15:8] <= pwdata[7:0];
        end
    end

    // ****************************************
    // Control register with hardware flags
    // ****************************************
    // Flags: hardware set wins over a software write of zero
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `TTCRB_RST_CTRL;
        end
        else
        begin
            if (wr && hit_ctrl)
            begin
                ctrl_q <= pwdata[7:0];
            end
            if (set_ovf)
            begin
                ctrl_q[`TTCRB_B_OVF] <= 1'b1;
            end
            if (set_ext)
            begin
                ctrl_q[`TTCRB_B_EXT] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupt status, clear and enable
    // ****************************************
    wire [1:0] evt = {set_ext, set_ovf};
    wire [1:0] clr = (wr && hit_icl) ? pwdata[1:0] : 2'b00;

    // Per-event sticky bit; set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_irq
            always @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    irq_stat_q[gi] <= 1'b0;
                end
                else if (evt[gi])
                begin
                    irq_stat_q[gi] <= 1'b1;
                end
                else if (clr[gi])
                begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Enable register
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_en_q <= `TTCRB_RST_IRQ;
        end
        else if (wr && hit_ien)
        begin
            irq_en_q <= pwdata[1:0];
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    // One cycle of latency keeps every output straight from a flop
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq <= 1'b0;
            baud_ovf_pulse <= 1'b0;
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end
        else
        begin
            irq <= |((irq_stat_q | evt) & irq_en_q & ~(clr & ~evt));
            baud_ovf_pulse <= roll & (mode == MODE_BAUD);
            rx_baud_tick <= rx_sel ? (roll & (mode == MODE_BAUD))
                : other_timer_ovf;
            tx_baud_tick <= tx_sel ? (roll & (mode == MODE_BAUD))
                : other_timer_ovf;
        end
    end

    // Limitation: pin edges closer than two cycles may merge
    // and then act only once

endmodule

// *** src/ttcrb_map.vh ***
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the timer module only; definitions only
`ifndef TTCRB_MAP_VH
`define TTCRB_MAP_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define TTCRB_IDX_CTRL 8'hc8
`define TTCRB_IDX_RCAP_LO 8'hca
`define TTCRB_IDX_RCAP_HI 8'hcb
`define TTCRB_IDX_CNT_LO 8'hcc
`define TTCRB_IDX_CNT_HI 8'hcd
`define TTCRB_IDX_IRQ_STAT 8'hd0
`define TTCRB_IDX_IRQ_CLR 8'hd1
`define TTCRB_IDX_IRQ_EN 8'hd2

// ****************************************
// Control register fields
// ****************************************
`define TTCRB_B_OVF 7
`define TTCRB_B_EXT 6
`define TTCRB_B_RXSEL 5
`define TTCRB_B_TXSEL 4
`define TTCRB_B_EXEN 3
`define TTCRB_B_RUN 2
`define TTCRB_B_CNTSRC 1
`define TTCRB_B_CAPSEL 0

// ****************************************
// Interrupt status, clear and enable fields
// ****************************************
`define TTCRB_IRQ_OVF 0
`define TTCRB_IRQ_EXT 1

// ****************************************
// Reset values
// ****************************************
`define TTCRB_RST_CTRL 8'h00
`define TTCRB_RST_RCAP 16'h0000
`define TTCRB_RST_CNT 16'h0000
`define TTCRB_RST_IRQ 2'b00

// ****************************************
// Timing: core-clock ticks per count
// ****************************************
`define TTCRB_DIV_TIMER 4'd12
`define TTCRB_DIV_BAUD 4'd2

`endif

// *** verification/ttcrb_chk_properties.sv ***
// Port-level checker for the timer block
// Assumes one clock domain; reset_n asynchronous, active low
`timescale 1ns/1ps
module ttcrb_chk (
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire other_timer_ovf,
    input wire rx_baud_tick,
    input wire tx_baud_tick,
    input wire baud_ovf_pulse,
    input wire irq
);
    // ****************************************
    // Shadows of baud select and irq enable
    // ****************************************
    logic [1:0] sel_q;
    logic [1:0] en_q;
    wire wr_ok = psel && penable && pready && pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Updated on the edge the write lands
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_q <= 2'b00;
            en_q <= 2'b00;
        end
        else if (wr_ok && paddr == 12'h320)
            sel_q <= pwdata[5:4];
        else if (wr_ok && paddr == 12'h348)
            en_q <= pwdata[1:0];
    end
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_unmap; psel && penable && pready && paddr == 12'h324 |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped accepted");
    property p_rx0; !sel_q[1] |=> rx_baud_tick == $past(other_timer_ovf); endproperty
    a_rx0: assert property (p_rx0) else $error("rx tick not other");
    property p_tx0; !sel_q[0] |=> tx_baud_tick == $past(other_timer_ovf); endproperty
    a_tx0: assert property (p_tx0) else $error("tx tick not other");
    property p_rx1; sel_q[1] && $past(sel_q[1]) |-> rx_baud_tick == baud_ovf_pulse; endproperty
    a_rx1: assert property (p_rx1) else $error("rx tick not own");
    property p_tx1; sel_q[0] && $past(sel_q[0]) |-> tx_baud_tick == baud_ovf_pulse; endproperty
    a_tx1: assert property (p_tx1) else $error("tx tick not own");
    property p_one; baud_ovf_pulse |=> !baud_ovf_pulse; endproperty
    a_one: assert property (p_one) else $error("pulse too long");
    property p_nobaud; sel_q == 2'b00 && $past(sel_q) == 2'b00 |-> !baud_ovf_pulse; endproperty
    a_nobaud: assert property (p_nobaud) else $error("pulse outside baud");
    property p_irq; en_q == 2'b00 && $past(en_q) == 2'b00 |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq while masked");
    c_baud: cover property (baud_ovf_pulse);
    c_rx: cover property (rx_baud_tick && sel_q[1]);
    c_irq: cover property (irq);
    c_err: cover property (pready && pslverr);
endmodule
bind ttcrb_timer ttcrb_chk u_chk (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .other_timer_ovf(other_timer_ovf), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .baud_ovf_pulse(baud_ovf_pulse), .irq(irq));

// *** verification/ttcrb_pins.sv ***
// Far-side model: count pin, trigger pin, other timer overflow
// Assumes bench asks for one falling edge per go pulse
`timescale 1ns/1ps
module ttcrb_pins (
    input wire clk,
    input wire reset_n,
    input wire trig_go,
    input wire cnt_go,
    output logic trigger_pin,
    output logic ext_count_pin,
    output logic other_timer_ovf
);
    // ****************************************
    // Pin low timers and overflow divider
    // ****************************************
    logic [1:0] tl_q;
    logic [1:0] cl_q;
    logic [2:0] ov_q;
    // Low for three cycles, beyond the two-cycle hold
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tl_q <= 2'd0;
            cl_q <= 2'd0;
            ov_q <= 3'd0;
        end
        else
        begin
            tl_q <= trig_go ? 2'd3 : (tl_q != 2'd0 ? tl_q - 2'd1 : 2'd0);
            cl_q <= cnt_go ? 2'd3 : (cl_q != 2'd0 ? cl_q - 2'd1 : 2'd0);
            ov_q <= (ov_q == 3'd4) ? 3'd0 : ov_q + 3'd1;
        end
    end
    // Pins idle at the pull-up level
    assign trigger_pin = (tl_q == 2'd0);
    assign ext_count_pin = (cl_q == 2'd0);
    assign other_timer_ovf = (ov_q == 3'd4);
endmodule

// *** verification/timer_two_capture_reload_baud_bench.sv ***
// Self-checking bench for the timer block over APB
// Assumes the pin model drives the far-side pins
`timescale 1ns/1ps
module timer_two_capture_reload_baud_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic trig_go = 1'b0;
    logic cnt_go = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, ext_count_pin, trigger_pin, other_timer_ovf;
    wire rx_baud_tick, tx_baud_tick, baud_ovf_pulse, irq;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int bauds = 0;
    logic [31:0] rdv;
    logic err;
    always #12.5 clk = ~clk;
    ttcrb_timer u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .trigger_pin(trigger_pin),
        .other_timer_ovf(other_timer_ovf), .rx_baud_tick(rx_baud_tick),
        .tx_baud_tick(tx_baud_tick), .baud_ovf_pulse(baud_ovf_pulse), .irq(irq));
    ttcrb_pins u_pins (.clk(clk), .reset_n(reset_n), .trig_go(trig_go), .cnt_go(cnt_go),
        .trigger_pin(trigger_pin), .ext_count_pin(ext_count_pin),
        .other_timer_ovf(other_timer_ovf));
    // ****************************************
    // Tasks
    // ****************************************
    task complete_run;
    begin
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    begin
        checks_done = checks_done + 1;
        if (g !== x)
        begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    end
    endtask
    // Holds the request until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
    begin
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), x, rdv);
    end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One falling edge on the trigger (t=1) or count pin
    task pin(input logic t);
    begin
        if (t)
            trig_go <= 1'b1;
        else
            cnt_go <= 1'b1;
        @(posedge clk);
        trig_go <= 1'b0;
        cnt_go <= 1'b0;
        idle(8);
    end
    endtask
    // Hang guard and baud pulse tally
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (baud_ovf_pulse === 1'b1)
            bauds <= bauds + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            complete_run();
        end
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        idle(5);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(12'h320, 32'h0);
        for (int i = 0; i < 4; i++)
            rd(12'h328 + 12'(i * 4), 32'h0);
        apb(1'b0, 12'h324, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        wr(12'h328, 32'h34);
        wr(12'h32c, 32'h12);
        rd(12'h328, 32'h34);
        wr(12'h330, 32'hff);
        wr(12'h334, 32'hff);
        wr(12'h320, 32'h04);
        idle(40);
        rd(12'h320, 32'h84);
        rd(12'h334, 32'h12);
        rd(12'h340, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(12'h348, 32'h1);
        idle(2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'h344, 32'h1);
        idle(2);
        chk("irq", 32'h0, {31'h0, irq});
        // Stopped timer: a known count must stay put over two ticks
        wr(12'h320, 32'h00);
        wr(12'h330, 32'h5a);
        idle(30);
        rd(12'h330, 32'h5a);
        wr(12'h334, 32'h0);
        wr(12'h320, 32'h0c);
        pin(1'b1);
        rd(12'h334, 32'h12);
        rd(12'h320, 32'h4c);
        wr(12'h320, 32'h04);
        wr(12'h334, 32'h0);
        pin(1'b1);
        rd(12'h334, 32'h0);
        rd(12'h320, 32'h04);
        wr(12'h320, 32'h00);
        wr(12'h334, 32'h77);
        wr(12'h32c, 32'h0);
        wr(12'h320, 32'h0d);
        pin(1'b1);
        rd(12'h32c, 32'h77);
        wr(12'h320, 32'h00);
        wr(12'h330, 32'h0);
        wr(12'h334, 32'h0);
        wr(12'h320, 32'h06);
        repeat (3) pin(1'b0);
        rd(12'h330, 32'h3);
        // Capture mode wraps to zero, no reload from the pair
        wr(12'h320, 32'h00);
        wr(12'h330, 32'hfe);
        wr(12'h334, 32'hff);
        wr(12'h320, 32'h05);
        idle(40);
        rd(12'h320, 32'h85);
        rd(12'h334, 32'h0);
        wr(12'h320, 32'h00);
        wr(12'h328, 32'hf0);
        wr(12'h32c, 32'hff);
        wr(12'h330, 32'hf0);
        wr(12'h334, 32'hff);
        wr(12'h320, 32'h3c);
        idle(100);
        chk("baud", 32'h1, {31'h0, bauds != 0});
        pin(1'b1);
        rd(12'h320, 32'h7c);
        complete_run();
    end
endmodule
